// >>> hdl/spq_pkg.sv
// register map, field positions and timing constants of the serial port
package spq_pkg;
  // register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam logic [3:0] DATA_OFS = 4'h8;
  // control_reg fields
  localparam int CTRL_EN   = 0;
  localparam int CTRL_ROLE = 1;
  localparam int CTRL_CLOCK_POLARITY_SELECT = 2;
  localparam int CTRL_CLOCK_PHASE_SELECT = 3;
  localparam int CTRL_RATE = 4;
  localparam logic [5:0] CTRL_RST = 6'h00;
  // status_control_reg fields
  localparam int STAT_ERROR_IRQ_ENABLE = 0;
  localparam int STAT_SELEN = 1;
  localparam int STAT_TXE   = 3;
  localparam int STAT_SELC  = 4;
  localparam int STAT_OVR   = 6;
  localparam int STAT_RXF   = 7;
  // serial clock half periods in bus cycles for rate codes 0..3
  localparam logic [6:0] HALF_R0 = 7'h01;
  localparam logic [6:0] HALF_R1 = 7'h04;
  localparam logic [6:0] HALF_R2 = 7'h10;
  localparam logic [6:0] HALF_R3 = 7'h40;
  // clock edge index within a byte (16 edges)
  localparam logic [3:0] LAST_EDGE = 4'hf;
  localparam logic [3:0] OVR_EDGE0 = 4'hc;
  localparam logic [3:0] OVR_EDGE1 = 4'hd;
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } spq_state_type;
endpackage

// >>> hdl/spq_spi_port.sv
// serial peripheral port: transmit queue, receive flags, overrun and select conflict
// What this block does
// R1: master starts a queued byte right after the current transfer ends
// R2: data write clears tx empty flag; load into shifter sets it again
// R3: software writes data only while tx empty flag is one
// R4: completed byte sets rx full; status read then data read clears it
// R5: without a new byte the shifter contents go out next transfer
// R6: idle port loads buffered byte and sets tx empty within two cycles
// R7: busy slave keeps buffered byte until its transfer completes
// R8: overrun sets if rx still full at the seventh capture edge
// R9: during overrun new bytes neither enter rx register nor set rx full
// R10: overrun clears by status read then data read
// R11: overrun or select conflict raise error irq when irq enable set
// R12: software rereads status after data read if error irq off
// R13: role bit picks clock and mosi as outputs, or miso as output
// R14: conflict when slave select rises mid transfer or master select low
// R15: conflict flag sets only while its enable is one
// R16: master conflict clears enable, empties queue, stops, releases pins
// R17: slave phase 0 starts on select fall; phase 1 on first clock edge
// R18: conflict leaves the role bit unchanged
// R19: phase 0 slave select then deselect faults even with no clocks
// R20: slave conflict leaves enable and slave state alone
// R21: deselected slave floats miso and ignores every clock edge
// R22: conflict clears by status read then control write, no fault present
//
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/1ns
module spq_spi_port (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // serial pins
  input  wire logic        sclkI,
  output logic             sclkO,
  output logic             sclkOe,
  input  wire logic        mosiI,
  output logic             mosiO,
  output logic             mosiOe,
  input  wire logic        misoI,
  output logic             misoO,
  output logic             misoOe,
  input  wire logic        ssN,
  // system side
  output logic             errIrq,
  output logic             pinsOwned
);

  function automatic logic isReg(input logic [3:0] a, input logic [3:0] ofs);
    isReg = (a == ofs);
  endfunction

  logic [5:0]              ctrlQ;
  logic                    errIeQ;
  logic                    selEnQ;
  logic [7:0]              txBufQ;
  logic                    txFullQ;
  logic [7:0]              rxBufQ;
  logic                    rxFullQ;
  logic                    ovrQ;
  logic                    selcQ;
  logic                    rxArmQ;
  logic                    ovrArmQ;
  logic                    selArmQ;
  logic [7:0]              shQ;
  logic                    rxBitQ;
  logic [3:0]              edgeQ;
  logic [6:0]              divQ;
  logic                    sclkQ;
  logic [3:0]              syncAQ;
  logic [3:0]              syncBQ;
  logic                    sclkPrevQ;
  logic                    ssPrevQ;
  logic                    ackQ;
  logic [31:0]             datQ;
  spq_pkg::spq_state_type  stQ;
  spq_pkg::spq_state_type  stD;

  // bus decode
  wire busReq = cyc_i & stb_i & ~ackQ;
  wire wr     = busReq & we_i & sel_i[0];
  wire rd     = busReq & ~we_i;
  wire ctrlWr = wr & isReg(adr_i, spq_pkg::CTRL_OFS);
  wire statWr = wr & isReg(adr_i, spq_pkg::STAT_OFS);
  wire dataWr = wr & isReg(adr_i, spq_pkg::DATA_OFS);
  wire statRd = rd & isReg(adr_i, spq_pkg::STAT_OFS);
  wire dataRd = rd & isReg(adr_i, spq_pkg::DATA_OFS);

  // control fields
  wire       en     = ctrlQ[spq_pkg::CTRL_EN];
  wire       role   = ctrlQ[spq_pkg::CTRL_ROLE];
  wire       clock_polarity_select   = ctrlQ[spq_pkg::CTRL_CLOCK_POLARITY_SELECT];
  wire       clock_phase_select   = ctrlQ[spq_pkg::CTRL_CLOCK_PHASE_SELECT];
  wire [1:0] rate   = ctrlQ[spq_pkg::CTRL_RATE +: 2];
  wire [6:0] halfDiv = (rate == 2'h0) ? spq_pkg::HALF_R0 :
                       (rate == 2'h1) ? spq_pkg::HALF_R1 :
                       (rate == 2'h2) ? spq_pkg::HALF_R2 : spq_pkg::HALF_R3;

  // synchronised pins
  wire sclkS = syncBQ[0];
  wire mosiS = syncBQ[1];
  wire misoS = syncBQ[2];
  wire ssS   = syncBQ[3];

  wire master = en & role;
  wire slave  = en & ~role;
  wire active = (stQ == spq_pkg::ST_RUN);
  wire sclkEdge = (sclkS != sclkPrevQ);

  // transfer events
  wire mTick   = master & active & (divQ == 7'h00);
  wire sEdge   = slave & ~ssS & active & sclkEdge;                       // see R21
  wire sStart0 = slave & ~clock_phase_select & ~active & ssPrevQ & ~ssS;                // see R17
  wire sStart1 = slave & clock_phase_select & ~active & ~ssS & sclkEdge & (sclkS != clock_polarity_select); // see R17
  wire ev      = mTick | sEdge;
  wire lastEv  = ev & (edgeQ == spq_pkg::LAST_EDGE);
  wire sampleEv = ev & (edgeQ[0] == clock_phase_select);
  wire shiftEv = ev & (edgeQ[0] != clock_phase_select) & (edgeQ != spq_pkg::LAST_EDGE) &
                 (edgeQ != 4'h0);
  wire inBit   = role ? misoS : mosiS;
  wire [7:0] rxByte = {shQ[6:0], clock_phase_select ? inBit : rxBitQ};
  wire ovrStrobe = sampleEv &
                   (edgeQ == (clock_phase_select ? spq_pkg::OVR_EDGE1 : spq_pkg::OVR_EDGE0));

  // select conflict: master select low, or slave deselected mid transfer
  wire faultCond = selEnQ & ((master & ~ssS) | (slave & active & ssS));  // see R14 R15 R19
  wire mFault    = faultCond & master;
  wire mStart    = master & ~active & txFullQ & ~mFault;                 // see R1
  wire loadTx    = txFullQ & en & ~active & ~mFault;                     // see R6 R7

  wire rxSet  = lastEv & ~ovrQ;                                          // see R4 R9
  wire rxClr  = rxArmQ & dataRd;
  wire ovrSet = ovrStrobe & rxFullQ;                                     // see R8
  wire ovrClr = ovrArmQ & dataRd;                                        // see R10
  wire selClr = selArmQ & ctrlWr & ~faultCond;                           // see R22

  always_comb begin
    stD = stQ;
    case (stQ)
      spq_pkg::ST_IDLE: begin
        if (en & (mStart | sStart0 | sStart1)) begin
          stD = spq_pkg::ST_RUN;
        end
      end
      spq_pkg::ST_RUN: begin
        if (lastEv) begin
          stD = spq_pkg::ST_IDLE;
        end
      end
      default: stD = spq_pkg::ST_IDLE;
    endcase
    if (~en | mFault) begin
      stD = spq_pkg::ST_IDLE;                                            // see R16
    end
  end

  // bus slave: every access acknowledged one cycle after it is seen
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ackQ <= 1'b0;
      datQ <= 32'h0000_0000;
    end else begin
      ackQ <= busReq;
      if (rd) begin
        datQ <= 32'h0000_0000;
        if (isReg(adr_i, spq_pkg::CTRL_OFS)) begin
          datQ[5:0] <= ctrlQ;
        end
        if (isReg(adr_i, spq_pkg::STAT_OFS)) begin
          datQ[7:0] <= {rxFullQ, ovrQ, 1'b0, selcQ, ~txFullQ, 1'b0, selEnQ, errIeQ};
        end
        if (isReg(adr_i, spq_pkg::DATA_OFS)) begin
          datQ[7:0] <= rxBufQ;
        end
      end
    end
  end

  // control and status registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrlQ  <= spq_pkg::CTRL_RST;
      errIeQ <= 1'b0;
      selEnQ <= 1'b0;
    end else begin
      if (ctrlWr) begin
        ctrlQ <= dat_i[5:0];
      end
      if (mFault) begin
        ctrlQ[spq_pkg::CTRL_EN] <= 1'b0;                                 // see R16 R18
      end
      if (statWr) begin
        errIeQ <= dat_i[spq_pkg::STAT_ERROR_IRQ_ENABLE];
        selEnQ <= dat_i[spq_pkg::STAT_SELEN];
      end
    end
  end

  // transmit queue
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      txBufQ  <= 8'h00;
      txFullQ <= 1'b0;
    end else if (dataWr) begin
      txBufQ  <= dat_i[7:0];
      txFullQ <= 1'b1;                                                   // see R2
    end else if (loadTx | ~en | mFault) begin
      txFullQ <= 1'b0;                                                   // see R2 R16
    end
  end

  // receive register and flags, set wins over clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rxBufQ  <= 8'h00;
      rxFullQ <= 1'b0;
      ovrQ    <= 1'b0;
      selcQ   <= 1'b0;
      rxArmQ  <= 1'b0;
      ovrArmQ <= 1'b0;
      selArmQ <= 1'b0;
    end else begin
      if (rxSet) begin
        rxBufQ <= rxByte;                                                // see R4
      end
      rxFullQ <= rxSet | (rxFullQ & ~rxClr);                             // see R4
      ovrQ    <= ovrSet | (ovrQ & ~ovrClr);                              // see R8 R10
      selcQ   <= faultCond | (selcQ & ~selClr);                          // see R15 R22
      if (statRd & rxFullQ) begin
        rxArmQ <= 1'b1;
      end else if (dataRd) begin
        rxArmQ <= 1'b0;
      end
      if (statRd & ovrQ) begin
        ovrArmQ <= 1'b1;
      end else if (dataRd) begin
        ovrArmQ <= 1'b0;
      end
      if (statRd & selcQ & ~faultCond) begin
        selArmQ <= 1'b1;
      end else if (ctrlWr | faultCond) begin
        selArmQ <= 1'b0;
      end
    end
  end

  // pin synchronisers and edge history
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      syncAQ    <= 4'h8;
      syncBQ    <= 4'h8;
      sclkPrevQ <= 1'b0;
      ssPrevQ   <= 1'b1;
    end else begin
      syncAQ    <= {ssN, misoI, mosiI, sclkI};
      syncBQ    <= syncAQ;
      sclkPrevQ <= sclkS;
      ssPrevQ   <= ssS;
    end
  end

  // shift engine, shared by both roles
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stQ    <= spq_pkg::ST_IDLE;
      shQ    <= 8'h00;
      rxBitQ <= 1'b0;
      edgeQ  <= 4'h0;
      divQ   <= 7'h00;
      sclkQ  <= 1'b0;
    end else begin
      stQ <= stD;
      if (~en | mFault) begin
        shQ   <= 8'h00;
        edgeQ <= 4'h0;                                                   // see R16
        sclkQ <= clock_polarity_select;
        divQ  <= halfDiv - 7'h01;
      end else begin
        if (loadTx) begin
          shQ <= txBufQ;                                                 // see R5 R7
        end else if (lastEv) begin
          shQ <= rxByte;
        end else if (shiftEv) begin
          shQ <= {shQ[6:0], rxBitQ};
        end
        if (sampleEv) begin
          rxBitQ <= inBit;
        end
        if (sStart1) begin
          edgeQ <= 4'h1;
        end else if (~active) begin
          edgeQ <= 4'h0;
        end else if (ev) begin
          edgeQ <= edgeQ + 4'h1;
        end
        if (~active | mTick) begin
          divQ <= halfDiv - 7'h01;
        end else begin
          divQ <= divQ - 7'h01;
        end
        if (~active) begin
          sclkQ <= clock_polarity_select;
        end else if (mTick) begin
          sclkQ <= ~sclkQ;
        end
      end
    end
  end

  // outputs
  assign dat_o     = datQ;
  assign ack_o     = ackQ;
  assign sclkO     = sclkQ;
  assign sclkOe    = master;                                             // see R13
  assign mosiO     = shQ[7];
  assign mosiOe    = master;                                             // see R13
  assign misoO     = shQ[7];
  assign misoOe    = slave & ~ssS;                                       // see R13 R21
  assign errIrq    = errIeQ & (ovrQ | selcQ);                            // see R11
  assign pinsOwned = en;                                                 // see R16

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  chk_tx_write_full: assert property (dataWr |=> txFullQ) // see R2
    else $error("data write did not fill the queue");
  chk_tx_load_empty: assert property (loadTx && !dataWr |=> !txFullQ && shQ == $past(txBufQ)) // see R6
    else $error("queued byte not moved to shifter");
  chk_slave_hold: assert property (slave && active && txFullQ && !lastEv && !ctrlWr
                                   |=> txFullQ) // see R7
    else $error("busy slave consumed queued byte");
  chk_master_next: assert property (mStart |=> active ##1 !txFullQ || active) // see R1
    else $error("master did not start queued byte");
  chk_rx_capture: assert property (rxSet |=> rxFullQ && rxBufQ == $past(rxByte)) // see R4
    else $error("received byte not captured");
  chk_ovr_set: assert property (ovrSet |=> ovrQ) // see R8
    else $error("overrun not flagged");
  chk_ovr_block: assert property (lastEv && ovrQ |=> $stable(rxBufQ)) // see R9
    else $error("receive register overwritten during overrun");
  chk_irq_follow: assert property (errIeQ && $rose(ovrQ) |-> errIrq) // see R11
    else $error("error irq missing");
  chk_sel_gate: assert property (!selEnQ && !selcQ |=> !selcQ) // see R15
    else $error("conflict set while disabled");
  chk_master_fault: assert property (mFault |=> !en && !txFullQ && !active && !sclkOe) // see R16
    else $error("master conflict did not stop the port");
  chk_role_kept: assert property ($rose(selcQ) && !$past(ctrlWr) |-> $stable(role)) // see R18
    else $error("role changed by conflict");
  chk_miso_float: assert property (ssS && !role |-> !misoOe) // see R21
    else $error("miso driven while deselected");

endmodule

// >>> verification/spq_far_slave.sv
// far-side slave model answering the port while it is master
`timescale 1ns/1ns
module spq_far_slave #(
  parameter logic [7:0] RESP_BASE = 8'h35
) (
  // serial lines
  input  wire logic       sclk,
  input  wire logic       active,
  input  wire logic       mosi,
  output logic            miso,
  // traffic seen
  output logic      [7:0] rxByte,
  output logic      [7:0] prevByte,
  output logic      [7:0] frames
);
  logic       [7:0] shiftQ;
  logic       [7:0] inQ;
  logic       [2:0] bitQ;
  wire  logic [7:0] nextByte = RESP_BASE + frames;
  wire  logic       outBit   = (bitQ == 3'h0) ? nextByte[7] : shiftQ[7];
  // a released line shows the inverse so a stale level cannot pass
  assign miso = active ? outBit : ~outBit;
  initial begin
    bitQ = 3'h0;
    frames = 8'h00;
    shiftQ = 8'h00;
  end
  // capture on rising edges msb first, shift on falling edges
  always @(sclk) begin
    if (sclk === 1'b1) begin
      if (bitQ == 3'h0) shiftQ <= nextByte;
      inQ <= {inQ[6:0], mosi};
      if (bitQ == 3'h7) begin
        prevByte <= rxByte;
        rxByte <= {inQ[6:0], mosi};
        frames <= frames + 8'h01;
      end
      bitQ <= bitQ + 3'h1;
    end else if (bitQ != 3'h0) begin
      shiftQ <= shiftQ << 1;
    end
  end
endmodule

// >>> verification/spq_spi_port_tb.sv
// self-checking bench for the serial port
`timescale 1ns/1ns
module spq_spi_port_tb;
  logic             mclk, rstn, cyc, stb, we, bSclk, bMosi, ssN;
  logic      [3:0]  adr;
  logic      [31:0] wdat, rdat;
  logic      [7:0]  q;
  wire logic [31:0] datO;
  wire logic        ack, sclkO, sclkOe, mosiO, mosiOe, misoO, misoOe;
  wire logic        errIrq, pinsOwned, sclkI, mosiI, misoI, pMiso;
  wire logic [7:0]  rxByte, prevByte, frames;
  int               badCount, samplesChecked;

  assign sclkI = sclkOe ? sclkO : bSclk;
  assign mosiI = mosiOe ? mosiO : bMosi;
  assign misoI = misoOe ? misoO : pMiso;

  spq_spi_port dut_u (.mclk(mclk), .rstn(rstn), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(datO), .ack_o(ack),
    .sclkI(sclkI), .sclkO(sclkO), .sclkOe(sclkOe), .mosiI(mosiI), .mosiO(mosiO),
    .mosiOe(mosiOe), .misoI(misoI), .misoO(misoO), .misoOe(misoOe), .ssN(ssN),
    .errIrq(errIrq), .pinsOwned(pinsOwned));
  spq_far_slave far_u (.sclk(sclkO), .active(sclkOe), .mosi(mosiO), .miso(pMiso),
    .rxByte(rxByte), .prevByte(prevByte), .frames(frames));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic reportAndStop;
    if (badCount == 0 && samplesChecked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samplesChecked++;
    if (g !== e) begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // classic single cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 100);
    if (n >= 100) badCount++;
    rdat = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rdChk(input string nm, input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask
  task automatic waitIrq(input logic lvl);
    int n;
    n = 0;
    while (errIrq !== lvl && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    chk("errIrq", {31'h0, lvl}, {31'h0, errIrq});
  endtask
  // one byte as an external master, 160 ns clock period, msb first
  task automatic sbyte(input logic [7:0] d, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      bMosi <= d[i];
      repeat (8) @(posedge mclk);
      bSclk <= 1'b1;
      r[i] = misoI;
      repeat (8) @(posedge mclk);
      bSclk <= 1'b0;
    end
    repeat (8) @(posedge mclk);
  endtask

  initial begin
    rstn = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    wdat = 32'h0;
    bSclk = 1'b0;
    bMosi = 1'b0;
    ssN = 1'b1;
    badCount = 0;
    samplesChecked = 0;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    rdChk("ctrl", spq_pkg::CTRL_OFS, 32'h0);
    rdChk("stat", spq_pkg::STAT_OFS, 32'h08);
    chk("pinsOwned", 32'h0, {31'h0, pinsOwned});
    // master, rate code 1, error irq on; two bytes queued back to back
    bus(1'b1, spq_pkg::CTRL_OFS, 32'h13);
    bus(1'b1, spq_pkg::STAT_OFS, 32'h01);
    bus(1'b1, spq_pkg::DATA_OFS, 32'ha5);
    rdChk("stat", spq_pkg::STAT_OFS, 32'h09);
    bus(1'b1, spq_pkg::DATA_OFS, 32'h3c);
    rdChk("stat", spq_pkg::STAT_OFS, 32'h01);
    waitIrq(1'b1);
    rdChk("stat", spq_pkg::STAT_OFS, 32'hc9);
    // the overrun strobe comes before the last clock edges of the second byte
    repeat (20) @(posedge mclk);
    chk("mosi", 32'h3ca5, {16'h0, rxByte, prevByte});
    rdChk("data", spq_pkg::DATA_OFS, 32'h35);
    rdChk("stat", spq_pkg::STAT_OFS, 32'h09);
    waitIrq(1'b0);
    // master select conflict
    bus(1'b1, spq_pkg::STAT_OFS, 32'h03);
    ssN <= 1'b0;
    waitIrq(1'b1);
    rdChk("ctrl", spq_pkg::CTRL_OFS, 32'h12);
    rdChk("stat", spq_pkg::STAT_OFS, 32'h1b);
    chk("pins", 32'h0, {30'h0, pinsOwned, sclkOe});
    ssN <= 1'b1;
    repeat (4) @(posedge mclk);
    rdChk("stat", spq_pkg::STAT_OFS, 32'h1b);
    bus(1'b1, spq_pkg::CTRL_OFS, 32'h12);
    rdChk("stat", spq_pkg::STAT_OFS, 32'h0b);
    bus(1'b1, spq_pkg::STAT_OFS, 32'h01);
    bus(1'b1, spq_pkg::CTRL_OFS, 32'h13);
    ssN <= 1'b0;
    repeat (8) @(posedge mclk);
    rdChk("stat", spq_pkg::STAT_OFS, 32'h09);
    chk("pins", 32'h3, {30'h0, pinsOwned, sclkOe});
    ssN <= 1'b1;
    // slave, phase 0
    bus(1'b1, spq_pkg::CTRL_OFS, 32'h01);
    bus(1'b1, spq_pkg::DATA_OFS, 32'hc3);
    rdChk("stat", spq_pkg::STAT_OFS, 32'h09);
    sbyte(8'h55, q);
    rdChk("stat", spq_pkg::STAT_OFS, 32'h09);
    chk("misoOe", 32'h0, {31'h0, misoOe});
    ssN <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("misoOe", 32'h1, {31'h0, misoOe});
    sbyte(8'h96, q);
    chk("miso", 32'hc3, {24'h0, q});
    ssN <= 1'b1;
    repeat (4) @(posedge mclk);
    rdChk("stat", spq_pkg::STAT_OFS, 32'h89);
    rdChk("data", spq_pkg::DATA_OFS, 32'h96);
    rdChk("stat", spq_pkg::STAT_OFS, 32'h09);
    bus(1'b1, spq_pkg::STAT_OFS, 32'h03);
    ssN <= 1'b0;
    repeat (6) @(posedge mclk);
    ssN <= 1'b1;
    waitIrq(1'b1);
    rdChk("stat", spq_pkg::STAT_OFS, 32'h1b);
    rdChk("ctrl", spq_pkg::CTRL_OFS, 32'h01);
    reportAndStop;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    badCount++;
    reportAndStop;
  end
endmodule
